// >>> rs232_port_pkg.sv
// Purpose: Constants, types and register map of the RS232 handshake port.
// Assumes: One 125 MHz clock, AHB-Lite register access, one word each.
// Notes:   Logic level 1 means ON on every handshake line.
//
// Operation
// - Separate transmit and receive lines, full duplex
// - All outputs OFF after power on
// - Terminal ready ON only while port enabled
// - Request to send ON when data waits, except in manual mode
// - Switched request mode: signals automatic, software locked
// - Always-on mode: hardware flow control, software locked
// - No-data-set-ready mode ignores that input, locked
// - Manual mode: software reads inputs, sets outputs
// - Seven/eight data bits, start, one/two stops
// - Even, odd or no parity bit
package rs232_port_pkg;

   // -------------------------------------------------------------
   // Register map (byte addresses)
   // -------------------------------------------------------------
   localparam logic [7:0] ADDR_CTRL   = 8'h00;
   localparam logic [7:0] ADDR_BAUD   = 8'h04;
   localparam logic [7:0] ADDR_TXDATA = 8'h08;
   localparam logic [7:0] ADDR_RXDATA = 8'h0C;
   localparam logic [7:0] ADDR_STATUS = 8'h10;
   localparam logic [7:0] ADDR_SIGNAL = 8'h14;

   // -------------------------------------------------------------
   // Reset values
   // -------------------------------------------------------------
   // 115200 baud at 125 MHz
   localparam logic [15:0] BAUD_DIV_RST = 16'h043D;
   localparam logic [6:0]  CTRL_RST     = 7'h04;

   // -------------------------------------------------------------
   // Field positions
   // -------------------------------------------------------------
   localparam int STAT_TX_FULL = 0;
   localparam int STAT_TX_BUSY = 1;
   localparam int STAT_RX_VAL  = 2;
   localparam int STAT_PAR_ERR = 3;
   localparam int STAT_FRM_ERR = 4;
   localparam int STAT_OVERRUN = 5;
   localparam int SIG_DTR      = 0;
   localparam int SIG_RTS      = 1;

   // -------------------------------------------------------------
   // Types
   // -------------------------------------------------------------
   typedef enum logic [1:0] {
      FLOW_MANUAL,
      FLOW_RTS_SWITCHED,
      FLOW_RTS_ON,
      FLOW_RTS_ON_NO_DSR
   } flow_mode_t;

   // Control word, bit 0 upward: mode, width, stops, parity, enable
   typedef struct packed {
      logic       port_en;
      logic       parity_odd;
      logic       parity_en;
      logic       two_stop;
      logic       eight_bits;
      flow_mode_t flow;
   } ctrl_t;

   // Synchronised line inputs
   typedef struct packed {
      logic ring;
      logic carrier;
      logic clear_send;
      logic set_ready;
      logic rx_line;
   } line_in_t;

endpackage

// >>> rs232_handshake_port.sv
// Purpose: RS232 port with modem handshake lines and AHB-Lite registers.
// Assumes: Partner keeps its own handshake duties; lines sampled async.
// Notes:   Zero-wait bus slave; one-deep transmit holding register.
//
// The AHB-Lite register port and the register addresses were left to the implementer.
`timescale 1ns/1ps

module rs232_handshake_port
   import rs232_port_pkg::*;
(
   // Clock and reset
   input  wire logic        sys_clk,
   input  wire logic        rst,
   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   // Serial lines
   input  wire logic        rxd,
   output logic             txd,
   // Modem lines
   output logic             dtr,
   output logic             rts,
   input  wire logic        dsr,
   input  wire logic        cts,
   input  wire logic        dcd,
   input  wire logic        ri
);

   // ----------------------------------------------------------------
   // Input synchronisers
   // ----------------------------------------------------------------
   line_in_t in_meta_reg;
   line_in_t in_reg;

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         in_meta_reg <= '{default: 1'b0, rx_line: 1'b1};
         in_reg      <= '{default: 1'b0, rx_line: 1'b1};
      end else begin
         in_meta_reg <= '{ring: ri, carrier: dcd, clear_send: cts,
                          set_ready: dsr, rx_line: rxd};
         in_reg      <= in_meta_reg;
      end
   end

   // ----------------------------------------------------------------
   // Bus slave
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PARITY,
                             TX_STOP} tx_state_t;
   typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PARITY,
                             RX_STOP} rx_state_t;

   ctrl_t       ctrl_reg;
   logic [15:0] baud_reg;
   logic        sw_dtr_reg;
   logic        sw_rts_reg;
   logic [7:0]  tx_hold_reg;
   logic        tx_full_reg;
   logic [7:0]  rx_data_reg;
   logic        rx_valid_reg;
   logic        par_err_reg;
   logic        frm_err_reg;
   logic        overrun_reg;
   logic        wr_pend_reg;
   logic [7:0]  wr_addr_reg;
   tx_state_t   tx_state_reg;
   rx_state_t   rx_state_reg;

   logic        addr_phase;
   logic        wr_now;
   logic        rd_rx_now;
   logic [31:0] rd_next;

   assign addr_phase = hsel && htrans[1] && hready;
   assign wr_now     = wr_pend_reg;
   assign rd_rx_now  = addr_phase && !hwrite && haddr[7:0] == ADDR_RXDATA;

   always_comb begin
      rd_next = 32'h0000_0000;
      case (haddr[7:0])
         ADDR_CTRL:   rd_next[6:0]  = ctrl_reg;
         ADDR_BAUD:   rd_next[15:0] = baud_reg;
         ADDR_RXDATA: rd_next[7:0]  = rx_data_reg;
         ADDR_STATUS: rd_next[5:0]  = {overrun_reg, frm_err_reg,
                                       par_err_reg, rx_valid_reg,
                                       tx_state_reg != TX_IDLE,
                                       tx_full_reg};
         // Line states are readable in every mode
         ADDR_SIGNAL: rd_next[5:0]  = {in_reg.ring, in_reg.carrier,
                                       in_reg.clear_send, in_reg.set_ready,
                                       rts, dtr};
         default:     rd_next = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         hrdata      <= 32'h0000_0000;
         hreadyout   <= 1'b0;
         hresp       <= 1'b0;
         wr_pend_reg <= 1'b0;
         wr_addr_reg <= 8'h00;
      end else begin
         hreadyout   <= 1'b1;
         hresp       <= 1'b0;
         wr_pend_reg <= addr_phase && hwrite;
         wr_addr_reg <= haddr[7:0];
         if (addr_phase && !hwrite)
            hrdata <= rd_next;
      end
   end

   // Configuration and software line requests
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         ctrl_reg   <= CTRL_RST;
         baud_reg   <= BAUD_DIV_RST;
         sw_dtr_reg <= 1'b0;
         sw_rts_reg <= 1'b0;
      end else if (wr_now) begin
         case (wr_addr_reg)
            ADDR_CTRL: ctrl_reg <= hwdata[6:0];
            ADDR_BAUD: baud_reg <= hwdata[15:0];
            // Ignored while an automatic mode owns the lines
            ADDR_SIGNAL: if (ctrl_reg.flow == FLOW_MANUAL) begin
               sw_dtr_reg <= hwdata[SIG_DTR];
               sw_rts_reg <= hwdata[SIG_RTS];
            end
            default: ;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Handshake outputs
   // ----------------------------------------------------------------
   logic tx_start;
   logic tx_gate;
   logic dsr_ok;

   // Data set ready gates sending only where the mode honours it
   assign dsr_ok  = ctrl_reg.flow == FLOW_MANUAL ||
                    ctrl_reg.flow == FLOW_RTS_ON_NO_DSR ||
                    in_reg.set_ready;
   assign tx_gate = ctrl_reg.port_en && dsr_ok &&
                    (ctrl_reg.flow == FLOW_MANUAL ||
                     (in_reg.clear_send &&
                      (ctrl_reg.flow != FLOW_RTS_SWITCHED || rts)));
   assign tx_start = tx_state_reg == TX_IDLE && tx_full_reg && tx_gate;

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         dtr <= 1'b0;
         rts <= 1'b0;
      end else begin
         case (ctrl_reg.flow)
            FLOW_MANUAL: begin
               dtr <= ctrl_reg.port_en && sw_dtr_reg;
               rts <= ctrl_reg.port_en && sw_rts_reg;
            end
            // Request stays up until the last stop bit has gone
            FLOW_RTS_SWITCHED: begin
               dtr <= ctrl_reg.port_en;
               rts <= ctrl_reg.port_en &&
                      (tx_full_reg || tx_state_reg != TX_IDLE);
            end
            default: begin
               dtr <= ctrl_reg.port_en;
               rts <= ctrl_reg.port_en;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Transmitter
   // ----------------------------------------------------------------
   logic [7:0]  tx_shift_reg;
   logic        tx_par_reg;
   logic [2:0]  tx_idx_reg;
   logic [15:0] tx_cnt_reg;
   logic [2:0]  last_bit;

   assign last_bit = ctrl_reg.eight_bits ? 3'h7 : 3'h6;

   // Holding register: a write while full is dropped, not queued
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         tx_full_reg <= 1'b0;
         tx_hold_reg <= 8'h00;
      end else if (tx_start) begin
         tx_full_reg <= 1'b0;
      end else if (wr_now && wr_addr_reg == ADDR_TXDATA && !tx_full_reg) begin
         tx_full_reg <= 1'b1;
         tx_hold_reg <= hwdata[7:0];
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         tx_state_reg <= TX_IDLE;
         txd          <= 1'b1;
         tx_shift_reg <= 8'h00;
         tx_par_reg   <= 1'b0;
         tx_idx_reg   <= 3'h0;
         tx_cnt_reg   <= 16'h0000;
      end else if (tx_state_reg == TX_IDLE) begin
         txd <= 1'b1;
         if (tx_start) begin
            tx_shift_reg <= tx_hold_reg;
            tx_par_reg   <= ctrl_reg.parity_odd ^ (^(tx_hold_reg &
                            {ctrl_reg.eight_bits, 7'h7F}));
            txd          <= 1'b0;
            tx_cnt_reg   <= baud_reg - 16'h0001;
            tx_state_reg <= TX_START;
         end
      end else if (tx_cnt_reg != 16'h0000) begin
         tx_cnt_reg <= tx_cnt_reg - 16'h0001;
      end else begin
         tx_cnt_reg <= baud_reg - 16'h0001;
         case (tx_state_reg)
            TX_START: begin
               txd          <= tx_shift_reg[0];
               tx_shift_reg <= tx_shift_reg >> 1;
               tx_idx_reg   <= 3'h0;
               tx_state_reg <= TX_DATA;
            end
            TX_DATA: begin
               if (tx_idx_reg == last_bit) begin
                  tx_idx_reg <= 3'h0;
                  if (ctrl_reg.parity_en) begin
                     txd          <= tx_par_reg;
                     tx_state_reg <= TX_PARITY;
                  end else begin
                     txd          <= 1'b1;
                     tx_state_reg <= TX_STOP;
                  end
               end else begin
                  txd          <= tx_shift_reg[0];
                  tx_shift_reg <= tx_shift_reg >> 1;
                  tx_idx_reg   <= tx_idx_reg + 3'h1;
               end
            end
            TX_PARITY: begin
               txd          <= 1'b1;
               tx_state_reg <= TX_STOP;
            end
            TX_STOP: begin
               // Flow gate is checked again before the next start
               if (tx_idx_reg == {2'b00, ctrl_reg.two_stop})
                  tx_state_reg <= TX_IDLE;
               else
                  tx_idx_reg <= tx_idx_reg + 3'h1;
            end
            default: tx_state_reg <= TX_IDLE;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Receiver
   // ----------------------------------------------------------------
   logic [7:0]  rx_shift_reg;
   logic [2:0]  rx_idx_reg;
   logic [15:0] rx_cnt_reg;
   logic        rx_done;
   logic        rx_perr;
   logic        rx_ferr;

   assign rx_done = rx_state_reg == RX_STOP && rx_cnt_reg == 16'h0000;
   assign rx_ferr = rx_done && !in_reg.rx_line;
   assign rx_perr = rx_state_reg == RX_PARITY && rx_cnt_reg == 16'h0000 &&
                    (in_reg.rx_line != (ctrl_reg.parity_odd ^
                     (^rx_shift_reg)));

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         rx_state_reg <= RX_IDLE;
         rx_shift_reg <= 8'h00;
         rx_idx_reg   <= 3'h0;
         rx_cnt_reg   <= 16'h0000;
      end else if (rx_state_reg == RX_IDLE) begin
         // Runs beside the transmitter; starts only while the port is enabled
         if (!in_reg.rx_line && ctrl_reg.port_en) begin
            rx_cnt_reg   <= {1'b0, baud_reg[15:1]};
            rx_state_reg <= RX_START;
         end
      end else if (rx_cnt_reg != 16'h0000) begin
         rx_cnt_reg <= rx_cnt_reg - 16'h0001;
      end else begin
         rx_cnt_reg <= baud_reg - 16'h0001;
         case (rx_state_reg)
            // A start shorter than half a bit is treated as a glitch
            RX_START: begin
               rx_shift_reg <= 8'h00;
               rx_idx_reg   <= 3'h0;
               rx_state_reg <= in_reg.rx_line ? RX_IDLE : RX_DATA;
            end
            RX_DATA: begin
               rx_shift_reg[rx_idx_reg] <= in_reg.rx_line;
               rx_idx_reg <= rx_idx_reg + 3'h1;
               if (rx_idx_reg == last_bit)
                  rx_state_reg <= ctrl_reg.parity_en ? RX_PARITY : RX_STOP;
            end
            RX_PARITY: rx_state_reg <= RX_STOP;
            RX_STOP:   rx_state_reg <= RX_IDLE;
            default:   rx_state_reg <= RX_IDLE;
         endcase
      end
   end

   // Receive flags: a new event wins over a clear in the same cycle
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         rx_data_reg  <= 8'h00;
         rx_valid_reg <= 1'b0;
         par_err_reg  <= 1'b0;
         frm_err_reg  <= 1'b0;
         overrun_reg  <= 1'b0;
      end else begin
         if (rx_done) begin
            rx_data_reg  <= rx_shift_reg;
            rx_valid_reg <= 1'b1;
         end else if (rd_rx_now) begin
            rx_valid_reg <= 1'b0;
         end
         if (wr_now && wr_addr_reg == ADDR_STATUS) begin
            par_err_reg <= par_err_reg && !hwdata[STAT_PAR_ERR];
            frm_err_reg <= frm_err_reg && !hwdata[STAT_FRM_ERR];
            overrun_reg <= overrun_reg && !hwdata[STAT_OVERRUN];
         end
         if (rx_perr)
            par_err_reg <= 1'b1;
         if (rx_ferr)
            frm_err_reg <= 1'b1;
         if (rx_done && rx_valid_reg && !rd_rx_now)
            overrun_reg <= 1'b1;
      end
   end

endmodule // rs232_handshake_port

// >>> rs232_port_sva.sv
// Purpose: Port-level checks of the RS232 handshake port.
// Assumes: Sees only top ports; tracks CTRL writes on the bus itself.
// Notes:   Mode is rebuilt from bus writes, so no internal probes.
`timescale 1ns/1ps

module rs232_port_sva
   import rs232_port_pkg::*;
(
   // Clock and reset
   input wire logic        sys_clk,
   input wire logic        rst,
   // Bus
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [31:0] hwdata,
   input wire logic        hready,
   input wire logic        hreadyout,
   input wire logic        hresp,
   // Lines
   input wire logic        txd,
   input wire logic        dtr,
   input wire logic        rts
);
   // ----------------------------------------------------------
   // Shadow of the control register
   // ----------------------------------------------------------
   logic       wr_q;
   logic [7:0] wa_q;
   ctrl_t      ctrl_q;
   logic       en_q;
   logic       auto_q;
   logic       sw_q;
   logic       on_q;
   assign en_q   = ctrl_q.port_en;
   assign auto_q = (ctrl_q.flow != FLOW_MANUAL);
   assign sw_q   = (ctrl_q.flow == FLOW_RTS_SWITCHED);
   assign on_q   = ctrl_q.flow[1];
   always_ff @(posedge sys_clk) begin
      if (rst) wr_q <= 1'b0;
      else wr_q <= hsel && htrans[1] && hready && hwrite;
      wa_q <= haddr[7:0];
   end
   // Write lands at the data-phase edge, like the real register
   always_ff @(posedge sys_clk) begin
      if (rst) ctrl_q <= ctrl_t'(CTRL_RST);
      else if (wr_q && wa_q == ADDR_CTRL) ctrl_q <= ctrl_t'(hwdata[6:0]);
   end
   // ----------------------------------------------------------
   // Properties
   // ----------------------------------------------------------
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   property p_reset_off;
      disable iff (1'b0) rst |=> (!dtr && !rts && txd && !hreadyout);
   endproperty
   property p_zero_wait;
      !$past(rst) |=> hreadyout;
   endproperty
   property p_okay;
      !hresp;
   endproperty
   property p_dtr_needs_en;
      dtr |-> $past(en_q);
   endproperty
   property p_rts_needs_en;
      rts |-> $past(en_q);
   endproperty
   property p_dtr_auto;
      (en_q && auto_q) [*3] |-> dtr;
   endproperty
   property p_rts_on;
      (en_q && on_q) [*3] |-> rts;
   endproperty
   property p_sw_txd_rts;
      sw_q && $past(sw_q) && !txd |-> rts;
   endproperty
   a_reset_off: assert property (p_reset_off)
      else $error("outputs not OFF");
   a_zero_wait: assert property (p_zero_wait)
      else $error("bus wait seen");
   a_okay: assert property (p_okay)
      else $error("bus error response");
   a_dtr_needs_en: assert property (p_dtr_needs_en)
      else $error("dtr early");
   a_rts_needs_en: assert property (p_rts_needs_en)
      else $error("rts early");
   a_dtr_auto: assert property (p_dtr_auto)
      else $error("dtr not ON");
   a_rts_on: assert property (p_rts_on)
      else $error("rts not held ON");
   a_sw_txd_rts: assert property (p_sw_txd_rts)
      else $error("sent w/o rts");
   c_sw_start: cover property (sw_q && $fell(txd));
   c_sw_rts: cover property (sw_q && $rose(rts));
   c_no_dsr_tx: cover property (ctrl_q.flow == FLOW_RTS_ON_NO_DSR && !txd);
endmodule // rs232_port_sva

bind rs232_handshake_port rs232_port_sva u_sva (.sys_clk(sys_clk),
   .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
   .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
   .txd(txd), .dtr(dtr), .rts(rts));

// >>> rs232_partner.sv
// Purpose: Behavioural serial partner with handshake lines.
// Assumes: Bit time of BIT clocks; format given by the bench.
// Notes:   Clear to send follows request to send one clock late while accept is high.
`timescale 1ns/1ps

module rs232_partner #(parameter int BIT = 16) (
   // Clock
   input  wire logic       sys_clk,
   // From the port
   input  wire logic       txd,
   input  wire logic       rts,
   // To the port
   output logic            rxd,
   output logic            dsr,
   output logic            cts,
   output logic            dcd,
   output logic            ri,
   // Scenario control: fmt [0] eight bits [1] parity [2] odd
   input  wire logic       ready,
   input  wire logic       accept,
   input  wire logic       carrier,
   input  wire logic       ring,
   input  wire logic [2:0] fmt,
   output logic [7:0]      got,
   output logic            got_par,
   output logic            got_stop,
   output int              got_cnt
);
   assign dsr = ready;
   assign dcd = carrier;
   assign ri  = ring;
   always_ff @(posedge sys_clk) cts <= rts && accept;
   initial rxd = 1'b1;
   // Mid-bit sampler of the port's transmitter
   initial begin
      got_cnt = 0;
      forever begin
         @(negedge txd);
         repeat (BIT / 2) @(posedge sys_clk);
         got = 8'h00;
         for (int i = 0; i < (fmt[0] ? 8 : 7); i++) begin
            repeat (BIT) @(posedge sys_clk);
            got[i] = txd;
         end
         if (fmt[1]) begin
            repeat (BIT) @(posedge sys_clk);
            got_par = txd;
         end
         repeat (BIT) @(posedge sys_clk);
         got_stop = txd;
         got_cnt++;
      end
   end
   // One 8N1 character; caller enters just after a rising edge
   task automatic send_char(input logic [7:0] d);
      rxd <= 1'b0;
      repeat (BIT) @(posedge sys_clk);
      for (int i = 0; i < 8; i++) begin
         rxd <= d[i];
         repeat (BIT) @(posedge sys_clk);
      end
      rxd <= 1'b1;
      repeat (BIT) @(posedge sys_clk);
   endtask
endmodule // rs232_partner

// >>> rs232_handshake_port_bench.sv
// Purpose: Self-checking bench of the RS232 handshake port.
// Assumes: Zero-wait bus slave; bit time shortened to BIT clocks.
// Notes:   Partner model stands on the serial side.
`timescale 1ns/1ps

module rs232_handshake_port_bench;
   import rs232_port_pkg::*;
   localparam int BIT = 16;
   localparam logic [7:0] CTRLS [3] = '{8'h46, 8'h52, 8'h7E};
   localparam logic [7:0] DATAS [3] = '{8'hA5, 8'hD3, 8'h0F};
   localparam logic [2:0] FMTS  [3] = '{3'h1, 3'h2, 3'h7};
   logic        sys_clk, rst, hsel, hwrite, hreadyout, hresp, txd, dtr;
   logic        rts, rxd, dsr, cts, dcd, ri, ready, accept, carrier, ring;
   logic        got_par, got_stop;
   logic [1:0]  htrans;
   logic [2:0]  hsize, fmt;
   logic [7:0]  got, exp;
   logic [31:0] haddr, hwdata, hrdata, rd;
   int          got_cnt, failures, cmp_count;

   rs232_handshake_port u_dut (.sys_clk(sys_clk), .rst(rst), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .rxd(rxd), .txd(txd),
      .dtr(dtr), .rts(rts), .dsr(dsr), .cts(cts), .dcd(dcd), .ri(ri));
   rs232_partner #(.BIT(BIT)) u_partner (.sys_clk(sys_clk), .txd(txd),
      .rts(rts), .rxd(rxd), .dsr(dsr), .cts(cts), .dcd(dcd), .ri(ri),
      .ready(ready), .accept(accept), .carrier(carrier), .ring(ring),
      .fmt(fmt), .got(got), .got_par(got_par), .got_stop(got_stop),
      .got_cnt(got_cnt));

   initial sys_clk = 1'b0;
   always #4 sys_clk = ~sys_clk;

   // ----------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------
   task automatic check(input string name, input logic [15:0] seen, exp);
      cmp_count++;
      if (seen !== exp) begin
         failures++;
         $display("FAIL %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // Single transfer; entered just after a rising edge
   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
      haddr  <= {24'h000000, a};
      htrans <= 2'b10;
      hwrite <= w;
      @(posedge sys_clk);
      while (hreadyout !== 1'b1) @(posedge sys_clk);
      htrans <= 2'b00;
      hwdata <= d;
      @(posedge sys_clk);
      while (hreadyout !== 1'b1) @(posedge sys_clk);
      q = hrdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d, rd);
   endtask
   task automatic rdchk(input string name, input logic [7:0] a,
                        input logic [15:0] e);
      bus(1'b0, a, 32'h00000000, rd);
      check(name, rd[15:0], e);
   endtask
   // Bounded wait for the partner to collect n characters
   task automatic wait_rx(input int n);
      for (int i = 0; i < 40 * BIT && got_cnt < n; i++) @(posedge sys_clk);
      check("char count", 16'(got_cnt), 16'(n));
   endtask
   task automatic finish_test();
      $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   // ----------------------------------------------------------
   // Tests
   // ----------------------------------------------------------
   initial begin
      {rst, hsel, hsize} = {1'b1, 1'b1, 3'h2};
      {htrans, hwrite, haddr, hwdata} = '0;
      {ready, accept, carrier, ring, fmt} = {4'h0, 3'h1};
      {failures, cmp_count} = '0;
      repeat (6) @(posedge sys_clk);
      rst <= 1'b0;
      repeat (2) @(posedge sys_clk);
      check("txd idle", 16'(txd), 16'h0001);
      check("dtr off", 16'(dtr | rts), 16'h0000);
      rdchk("ctrl reset", ADDR_CTRL, 16'h0004);
      rdchk("baud reset", ADDR_BAUD, BAUD_DIV_RST);
      rdchk("unmapped", 8'h18, 16'h0000);
      $display("Test reset done");
      wr(ADDR_BAUD, BIT);
      wr(ADDR_CTRL, 32'h00000044);
      {ready, accept, carrier, ring} <= 4'hF;
      wr(ADDR_SIGNAL, 32'h00000003);
      repeat (6) @(posedge sys_clk);
      check("manual dtr rts", 16'({rts, dtr}), 16'h0003);
      rdchk("signals on", ADDR_SIGNAL, 16'h003F);
      wr(ADDR_SIGNAL, 32'h00000000);
      repeat (6) @(posedge sys_clk);
      rdchk("signals off", ADDR_SIGNAL, 16'h0034);
      $display("Test manual done");
      for (int k = 0; k < 3; k++) begin
         fmt <= FMTS[k];
         wr(ADDR_CTRL, 32'(CTRLS[k]));
         wr(ADDR_TXDATA, 32'(DATAS[k]));
         wait_rx(k + 1);
         exp = FMTS[k][0] ? DATAS[k] : (DATAS[k] & 8'h7F);
         check("tx data", 16'(got), 16'(exp));
         check("tx stop", 16'(got_stop), 16'h0001);
         if (FMTS[k][1])
            check("parity", 16'(got_par), 16'(^exp ^ FMTS[k][2]));
         repeat (3 * BIT) @(posedge sys_clk);
      end
      fmt <= 3'h1;
      wr(ADDR_CTRL, 32'h00000046);
      fork
         u_partner.send_char(8'h3C);
      join_none
      wr(ADDR_TXDATA, 32'h00000096);
      wait_rx(4);
      repeat (2 * BIT) @(posedge sys_clk);
      check("duplex tx", 16'(got), 16'h0096);
      rdchk("rx valid", ADDR_STATUS, 16'h0004);
      rdchk("rx data", ADDR_RXDATA, 16'h003C);
      rdchk("rx drained", ADDR_STATUS, 16'h0000);
      // Seven-bit frame sees bit 7 as a low stop; then a parity miss
      wr(ADDR_CTRL, 32'h00000042);
      u_partner.send_char(8'h3C);
      wr(ADDR_CTRL, 32'h00000056);
      u_partner.send_char(8'h3C);
      repeat (BIT) @(posedge sys_clk);
      rdchk("rx errors", ADDR_STATUS, 16'h003C);
      wr(ADDR_STATUS, 32'h00000038);
      @(posedge sys_clk);
      rdchk("errors cleared", ADDR_STATUS, 16'h0004);
      rdchk("parity rx data", ADDR_RXDATA, 16'h003C);
      wr(ADDR_CTRL, 32'h00000046);
      $display("Test formats done");
      ready <= 1'b0;
      wr(ADDR_TXDATA, 32'h00000011);
      repeat (20 * BIT) @(posedge sys_clk);
      check("held by dsr", 16'(got_cnt), 16'h0004);
      ready <= 1'b1;
      wait_rx(5);
      wr(ADDR_TXDATA, 32'h00000022);
      // Holding register takes the next write while the current character is sent
      repeat (BIT) @(posedge sys_clk);
      wr(ADDR_TXDATA, 32'h00000033);
      repeat (4 * BIT) @(posedge sys_clk);
      accept <= 1'b0;
      wait_rx(6);
      check("current done", 16'(got), 16'h0022);
      repeat (20 * BIT) @(posedge sys_clk);
      check("next held", 16'(got_cnt), 16'h0006);
      accept <= 1'b1;
      wait_rx(7);
      check("resumed", 16'(got), 16'h0033);
      ready <= 1'b0;
      wr(ADDR_CTRL, 32'h00000047);
      wr(ADDR_TXDATA, 32'h0000005A);
      wait_rx(8);
      check("dsr ignored", 16'(got), 16'h005A);
      $display("Test flow done");
      {ready, accept} <= 2'b10;
      wr(ADDR_CTRL, 32'h00000045);
      wr(ADDR_SIGNAL, 32'h00000003);
      repeat (6) @(posedge sys_clk);
      check("dtr locked", 16'({rts, dtr}), 16'h0001);
      wr(ADDR_TXDATA, 32'h00000069);
      repeat (8 * BIT) @(posedge sys_clk);
      check("rts waits", 16'({rts, 7'h00, got_cnt[7:0]}), 16'h8008);
      accept <= 1'b1;
      wait_rx(9);
      check("switched char", 16'(got), 16'h0069);
      repeat (3 * BIT) @(posedge sys_clk);
      check("rts dropped", 16'(rts), 16'h0000);
      wr(ADDR_CTRL, 32'h00000044);
      repeat (6) @(posedge sys_clk);
      check("sw locked", 16'({rts, dtr}), 16'h0000);
      $display("Test switched done");
      finish_test();
   end

   initial begin
      repeat (20000) @(posedge sys_clk);
      failures++;
      $display("FAIL watchdog expected done seen hang");
      finish_test();
   end
endmodule // rs232_handshake_port_bench
